// ---- hw/lfp_defs.vh ----
// Constants for the flash target port: field codes, address layout, cycle timing.
// Assumes inclusion by hw/lfp_target.v only; the bench uses literal values. Definitions only.
//
// Operation
// - Mode select high gives multiplexed programmer mode, low gives bus target mode.
// - Programmer mode takes 11-bit address in row/column halves, column high, 8 data bits.
// - Whole-array erase accepted only in programmer mode, never through bus cycles.
// - Protection program and block-erase sequences recognised as ordinary memory writes.
// - Every bus nibble is sampled at the rising clock edge.
// - Standby with frame high and idle engine; ready with frame low, bus idle.
// - Read starts with frame low, start nibble 0000, then type nibble 010X.
// - Write starts with frame low, start nibble 0000, then type nibble 011X.
// - Only the last start nibble before frame rises begins the cycle.
// - Type bits 3:2 must be 01, bit 1 is direction, bit 0 ignored.
// - Eight address nibbles, most significant first, assembled in that order.
// - Read: host turnaround in clocks 11 and 12, device takes bus in 12; the code first drives the bus in clock 13, with sync.
// - Read: device drives sync 0000 in clock 13, no wait states.
// - Data byte low nibble first; read clocks 14-15, write clocks 11-12.
// - Write: after host turnaround, device drives sync 0000 in clock 15.
// - Device drives 1111 in clock 16 then floats; host resumes in 17.
// - Frame low mid-cycle drops the cycle; 1111 from host returns to ready.
// - Aborting a poll read ends only the bus cycle; engine runs until reset.
// - Invalid fields or sequences are never signalled to the host.
// - Address bit 22 selects array when 1, register space when 0.
// - Address ID bits compared with straps; mismatch ignores the cycle.
// - ID bits sit in address bits 23 and 21:19, inverted from straps.
// - Either reset pin low deselects the device and releases the bus.
`ifndef LFP_DEFS_VH
`define LFP_DEFS_VH

`define LFP_START_CODE     4'h0
`define LFP_ABORT_CODE     4'hF
`define LFP_SYNC_READY     4'h0
`define LFP_TAR_CODE       4'hF
`define LFP_TYPE_MEM       2'h1
`define LFP_TYPE_HI        3
`define LFP_TYPE_LO        2
`define LFP_TYPE_DIR       1
`define LFP_ADDR_NIBBLES   4'h8
`define LFP_ID_HI_BIT      23
`define LFP_SPACE_BIT      22
`define LFP_ID_LO_MSB      21
`define LFP_ID_LO_LSB      19
`define LFP_ARRAY_MSB      18
`define LFP_MUX_ADDR_W     11
`define LFP_FIFO_DEPTH     8

`endif

// ---- hw/lfp_fifo.v ----
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module lfp_fifo #(
    parameter WIDTH = 40,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clock,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      cnt_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clock) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// ---- hw/lfp_target.v ----
// Target port of a flash device on a 4-bit multiplexed frame bus, with mode select.
// Assumes the bus clock is the block clock and pins are synchronous to it.
// Accepted writes leave through a FIFO towards the program/erase engine;
// reads take data from the array side at the end of the same cycle that carries the request.
`timescale 1ns/1ps
`include "lfp_defs.vh"
module lfp_target #(
    parameter MUX_AW = 11
) (
    input  wire                clock,
    input  wire                rst_b,
    input  wire                init_b,
    input  wire                mode_sel,
    input  wire [3:0]          strap_select_inputs,
    input  wire                frame_b,
    input  wire [3:0]          lad_in,
    output reg  [3:0]          lad_out,
    output reg                 lad_oe,
    input  wire [MUX_AW-1:0]   mux_addr,
    input  wire                row_col_sel,
    input  wire [7:0]          mux_data_in,
    input  wire                mux_we_b,
    input  wire                mux_oe_b,
    output reg  [7:0]          mux_data_out,
    output reg                 mux_data_oe,
    input  wire                engine_busy,
    output reg                 rd_req,
    output reg  [31:0]         rd_addr,
    output reg                 rd_space_array,
    input  wire [7:0]          rd_data,
    output reg                 wr_valid,
    output reg  [31:0]         wr_addr,
    output reg  [7:0]          wr_data,
    output reg                 wr_space_array,
    output reg                 wr_from_mux,
    input  wire                wr_ready,
    output reg                 standby,
    output reg                 mux_mode
);
    // ------------------------------------------------------------
    // Cycle states
    // ------------------------------------------------------------
    localparam [11:0] S_IDLE  = 12'h001;
    localparam [11:0] S_TYPE  = 12'h002;
    localparam [11:0] S_ADDR  = 12'h004;
    localparam [11:0] S_WDAT  = 12'h008;
    localparam [11:0] S_HTAR  = 12'h010;
    localparam [11:0] S_RWAIT = 12'h020;
    localparam [11:0] S_SYNC  = 12'h040;
    localparam [11:0] S_RDLO  = 12'h080;
    localparam [11:0] S_RDHI  = 12'h100;
    localparam [11:0] S_DTAR  = 12'h200;
    localparam [11:0] S_ABORT = 12'h400;
    localparam [11:0] S_SKIP  = 12'h800;

    wire        any_rst_b = rst_b & init_b;
    reg  [11:0] state_reg;
    reg  [11:0] state_next;
    reg  [3:0]  cnt_reg;
    reg  [31:0] addr_reg;
    reg  [7:0]  data_reg;
    reg         dir_wr_reg;
    reg         mode_reg;
    reg  [7:0]  rdat_reg;
    wire        f_ready;
    wire [40:0] f_out;
    wire        f_valid;
    reg  [40:0] f_in;
    reg         f_push;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [3:0] id_field = {addr_reg[`LFP_ID_HI_BIT],
                           addr_reg[`LFP_ID_LO_MSB:`LFP_ID_LO_LSB]};
    wire       id_match = (id_field == ~strap_select_inputs);
    wire       is_array = addr_reg[`LFP_SPACE_BIT];
    wire [3:0] type_nib = lad_in;
    wire       type_ok  = (type_nib[`LFP_TYPE_HI:`LFP_TYPE_LO] == `LFP_TYPE_MEM);

    // ------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        if (!frame_b) begin
            // A start nibble while frame is low restarts; only the last one counts.
            if (lad_in == `LFP_START_CODE) begin
                state_next = S_TYPE;
            end else if (state_reg != S_IDLE && state_reg != S_TYPE) begin
                state_next = S_ABORT;
            end else if (state_reg == S_TYPE) begin
                state_next = S_ABORT;
            end
        end else begin
            case (state_reg)
                S_IDLE:  state_next = S_IDLE;
                S_TYPE:  state_next = type_ok ? S_ADDR : S_SKIP;
                S_ADDR:  state_next = (cnt_reg == `LFP_ADDR_NIBBLES - 4'h1) ?
                                      (dir_wr_reg ? S_WDAT : S_HTAR) : S_ADDR;
                S_WDAT:  state_next = (cnt_reg == 4'h1) ? S_HTAR : S_WDAT;
                S_HTAR:  begin
                    // Reads leave after clock 11, writes after clock 14.
                    if (cnt_reg == (dir_wr_reg ? 4'h1 : 4'h0)) begin
                        // Mismatched ID or full FIFO: stay silent, never flag it.
                        if (!id_match || (dir_wr_reg && !f_ready)) begin
                            state_next = S_SKIP;
                        end else begin
                            state_next = dir_wr_reg ? S_SYNC : S_RWAIT;
                        end
                    end
                end
                S_RWAIT: state_next = S_SYNC;
                S_SYNC:  state_next = dir_wr_reg ? S_DTAR : S_RDLO;
                S_RDLO:  state_next = S_RDHI;
                S_RDHI:  state_next = S_DTAR;
                S_DTAR:  state_next = S_IDLE;
                S_ABORT: state_next = S_IDLE;
                S_SKIP:  state_next = S_SKIP;
                default: state_next = S_IDLE;
            endcase
        end
    end

    // HTAR covers clock 11 for reads and clocks 13-14 for writes; RWAIT is
    // clock 12, where the array data is taken, so sync lands on clock 13.
    always @(posedge clock or negedge any_rst_b) begin
        if (!any_rst_b) begin
            state_reg   <= S_IDLE;
            cnt_reg     <= 4'h0;
            addr_reg    <= 32'h0000_0000;
            data_reg    <= 8'h00;
            dir_wr_reg  <= 1'b0;
            rdat_reg    <= 8'h00;
        end else begin
            state_reg   <= (mode_reg) ? S_IDLE : state_next;
            if (state_next != state_reg) begin
                cnt_reg <= 4'h0;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
            if (state_reg == S_TYPE && frame_b) begin
                dir_wr_reg <= type_nib[`LFP_TYPE_DIR];
            end
            if (state_reg == S_ADDR) begin
                addr_reg <= {addr_reg[27:0], lad_in};
            end
            if (state_reg == S_WDAT) begin
                if (cnt_reg == 4'h0) begin
                    data_reg[3:0] <= lad_in;
                end else begin
                    data_reg[7:4] <= lad_in;
                end
            end
            if (state_reg == S_RWAIT) begin
                rdat_reg <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode capture and programmer-mode address mapping
    // ------------------------------------------------------------
    reg [MUX_AW-1:0] row_reg;
    reg [MUX_AW-1:0] col_reg;
    reg              mux_we_q_reg;

    // The mode strap is resampled every clock, so it must stay steady while in use.
    always @(posedge clock or negedge any_rst_b) begin
        if (!any_rst_b) begin
            mode_reg     <= 1'b0;
            row_reg      <= {MUX_AW{1'b0}};
            col_reg      <= {MUX_AW{1'b0}};
            mux_we_q_reg <= 1'b1;
            mux_mode     <= 1'b0;
        end else begin
            mode_reg     <= mode_sel;
            mux_mode     <= mode_sel;
            mux_we_q_reg <= mux_we_b;
            if (row_col_sel) begin
                row_reg <= mux_addr;
            end else begin
                col_reg <= mux_addr;
            end
        end
    end

    wire        mux_wr_edge = mode_reg && mux_we_q_reg && !mux_we_b;
    wire [31:0] mux_full    = {{(32-2*MUX_AW){1'b0}}, col_reg, row_reg};

    // ------------------------------------------------------------
    // Write path into the FIFO
    // ------------------------------------------------------------
    // Programmer-mode writes carry a flag so the engine may honour whole-array
    // erase only for them; bus writes never set it.
    always @* begin
        f_push = 1'b0;
        f_in   = {1'b0, 1'b0, 31'h0000_0000, 8'h00};
        if (mux_wr_edge) begin
            f_push = 1'b1;
            f_in   = {1'b1, 1'b1, mux_full[30:0], mux_data_in};
        end else if (!mode_reg && state_reg == S_HTAR && cnt_reg == 4'h1 && frame_b &&
                     dir_wr_reg && id_match) begin
            f_push = 1'b1;
            f_in   = {1'b0, is_array, addr_reg[30:0], data_reg};
        end
    end

    lfp_fifo #(
        .WIDTH (41),
        .DEPTH (`LFP_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clock     (clock),
        .rst_b     (any_rst_b),
        .in_data   (f_in),
        .in_valid  (f_push),
        .in_ready  (f_ready),
        .out_data  (f_out),
        .out_valid (f_valid),
        .out_ready (wr_ready)
    );

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // The engine is not touched by aborts; only reset stops it.
    always @(posedge clock or negedge any_rst_b) begin
        if (!any_rst_b) begin
            lad_out        <= `LFP_TAR_CODE;
            lad_oe         <= 1'b0;
            mux_data_out   <= 8'h00;
            mux_data_oe    <= 1'b0;
            rd_req         <= 1'b0;
            rd_addr        <= 32'h0000_0000;
            rd_space_array <= 1'b0;
            wr_valid       <= 1'b0;
            wr_addr        <= 32'h0000_0000;
            wr_data        <= 8'h00;
            wr_space_array <= 1'b0;
            wr_from_mux    <= 1'b0;
            standby        <= 1'b1;
        end else begin
            lad_oe  <= 1'b0;
            lad_out <= `LFP_TAR_CODE;
            if (frame_b && !mode_reg) begin
                case (state_next)
                    S_SYNC: begin
                        lad_oe  <= 1'b1;
                        lad_out <= `LFP_SYNC_READY;
                    end
                    S_RDLO: begin
                        lad_oe  <= 1'b1;
                        lad_out <= rdat_reg[3:0];
                    end
                    S_RDHI: begin
                        lad_oe  <= 1'b1;
                        lad_out <= rdat_reg[7:4];
                    end
                    S_DTAR: begin
                        lad_oe  <= 1'b1;
                        lad_out <= `LFP_TAR_CODE;
                    end
                    default: begin
                        lad_oe <= 1'b0;
                    end
                endcase
            end
            rd_req         <= !mode_reg && state_next == S_RWAIT;
            rd_addr        <= mode_reg ? mux_full : addr_reg;
            rd_space_array <= mode_reg ? 1'b1 : is_array;
            mux_data_oe    <= mode_reg && !mux_oe_b && mux_we_b;
            mux_data_out   <= rd_data;
            wr_valid       <= f_valid;
            wr_addr        <= {1'b0, f_out[38:8]};
            wr_data        <= f_out[7:0];
            wr_space_array <= f_out[39];
            wr_from_mux    <= f_out[40];
            standby        <= frame_b && state_next == S_IDLE && !engine_busy;
        end
    end
endmodule

// ---- test/lfp_host_model.sv ----
// Host controller model that runs single-byte memory cycles on the frame bus.
// Assumes the caller starts a cycle only after the previous one has ended.
`timescale 1ns/1ps
module lfp_host_model (
    input wire        clock,
    input wire [3:0]  lad_out,
    input wire        lad_oe,
    output logic       frame_b = 1'b1,
    output logic [3:0] lad_in = 4'hF
);
    // ----------------------------------------
    // Bus cycle tasks
    // ----------------------------------------
    task nib(input logic f, input logic [3:0] v);
        begin
            @(posedge clock);
            frame_b <= f;
            lad_in <= v;
        end
    endtask

    // Returns the clock number of the sync nibble, or zero when none came.
    task cyc(input logic [3:0] t, input logic [31:0] a, input logic [7:0] d,
             input integer pre, output logic [4:0] sc, output logic [7:0] rd);
        integer k;
        begin
            sc = 5'h00;
            rd = 8'h00;
            repeat (pre) nib(1'b0, 4'h0);
            nib(1'b0, 4'h0);
            nib(1'b1, t);
            for (k = 7; k >= 0; k = k - 1) nib(1'b1, a[k*4+:4]);
            if (t[1]) begin
                nib(1'b1, d[3:0]);
                nib(1'b1, d[7:4]);
            end
            nib(1'b1, 4'hF);
            // A released line shows a changing pattern so a stale value cannot pass.
            for (k = t[1] ? 13 : 11; k <= 16; k = k + 1) begin
                nib(1'b1, k == 16 ? 4'hF : ~lad_in);
                // Up to two clocks after sync are taken as data; on reads this leaves out the closing 1111, on writes it takes it in.
                if (lad_oe === 1'b1 && sc == 5'h00 && lad_out === 4'h0) sc = k[4:0];
                else if (lad_oe === 1'b1 && sc != 5'h00 && k <= sc + 2)
                    rd = {lad_out, rd[7:4]};
            end
        end
    endtask
endmodule

// ---- test/lfp_target_asserts.sv ----
// Pin-level checks for the flash target port, bound to every lfp_target.
// Assumes one clock and two active-low resets that are ANDed inside the design.
`timescale 1ns/1ps
module lfp_target_asserts (
    input wire        clock,
    input wire        rst_b,
    input wire        init_b,
    input wire [3:0]  strap_select_inputs,
    input wire        frame_b,
    input wire [3:0]  lad_out,
    input wire        lad_oe,
    input wire        mux_data_oe,
    input wire        mux_mode,
    input wire        standby,
    input wire        rd_req,
    input wire [31:0] rd_addr,
    input wire        rd_space_array,
    input wire        wr_valid,
    input wire [31:0] wr_addr,
    input wire        wr_space_array,
    input wire        wr_from_mux
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!(rst_b && init_b));

    sync_first_a: assert property ($rose(lad_oe) |-> lad_out == 4'h0)
        else $error("first driven nibble is not sync");
    tar_end_a: assert property ($fell(lad_oe) |-> $past(lad_out) == 4'hF)
        else $error("last driven nibble is not all ones");
    drive_len_a: assert property ($rose(lad_oe) |->
        (lad_oe [*2] ##1 !lad_oe) or (lad_oe [*4] ##1 !lad_oe))
        else $error("bus driven for a wrong number of cycles");
    // A read answers 12 cycles after its last start, a write 14 cycles after.
    sync_place_a: assert property ($rose(lad_oe) |->
        (!$past(frame_b, 12) && $past(frame_b, 11)) ||
        (!$past(frame_b, 14) && $past(frame_b, 13)))
        else $error("sync in the wrong clock of the cycle");
    mode_quiet_a: assert property (mux_mode |-> !lad_oe)
        else $error("bus driven in programmer mode");
    mux_drive_a: assert property (mux_data_oe |-> mux_mode)
        else $error("data pins driven outside programmer mode");
    abort_quiet_a: assert property (!frame_b |=> !lad_oe)
        else $error("bus driven after frame went low");
    ready_wake_a: assert property (!frame_b |=> !standby)
        else $error("standby while frame low");
    rd_sel_a: assert property (rd_req |-> rd_space_array == rd_addr[22] &&
        {rd_addr[23], rd_addr[21:19]} == ~strap_select_inputs)
        else $error("read issued with wrong id or space");
    wr_sel_a: assert property (wr_valid && !wr_from_mux |-> wr_space_array == wr_addr[22]
        && {wr_addr[23], wr_addr[21:19]} == ~strap_select_inputs)
        else $error("write queued with wrong id or space");

    cover property ($rose(lad_oe) ##4 !lad_oe);
    cover property ($rose(lad_oe) ##2 !lad_oe);
    cover property (wr_valid && wr_from_mux);
endmodule

bind lfp_target lfp_target_asserts chk_u (
    .clock(clock), .rst_b(rst_b), .init_b(init_b),
    .strap_select_inputs(strap_select_inputs), .frame_b(frame_b), .lad_out(lad_out),
    .lad_oe(lad_oe), .mux_data_oe(mux_data_oe), .mux_mode(mux_mode), .standby(standby),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_space_array(rd_space_array),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_space_array(wr_space_array),
    .wr_from_mux(wr_from_mux)
);

// ---- test/lfp_target_tb_top.sv ----
// Self-checking bench for the flash target port with a host model and a
// consumer that pops the write queue. Assumes lfp_target and lfp_fifo compiled.
`timescale 1ns/1ps
module lfp_target_tb_top;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        mode_sel = 1'b0;
    logic [10:0] mux_addr = 11'h000;
    logic        row_col_sel = 1'b0;
    logic [7:0]  mux_data_in = 8'h00;
    logic        mux_we_b = 1'b1;
    logic        wr_ready = 1'b0;
    logic        drain_en = 1'b1;
    logic        init_b = 1'b1;
    logic        mux_oe_b = 1'b1;
    logic        engine_busy = 1'b0;
    logic        wr_gap = 1'b0;
    logic [32:0] rd_last = 33'h0;
    logic [40:0] exp_q[$];
    logic [48:0] rows[0:7];
    logic [4:0]  sc, e;
    logic [7:0]  rd, d;
    logic [3:0]  t, lad_in, lad_out;
    logic [31:0] a, rd_addr, wr_addr;
    logic [7:0]  mux_data_out, wr_data;
    logic        frame_b, lad_oe, mux_data_oe, rd_req, rd_space_array, wr_valid;
    logic        wr_space_array, wr_from_mux, standby, mux_mode;
    integer      err_count = 0, comparisons = 0, i, n;
    wire  [7:0]  rd_data = rd_addr[7:0] ^ 8'h5A;

    lfp_target dut_u (.clock(clock), .rst_b(rst_b), .init_b(init_b), .mode_sel(mode_sel),
        .strap_select_inputs(4'h3), .frame_b(frame_b), .lad_in(lad_in),
        .lad_out(lad_out), .lad_oe(lad_oe), .mux_addr(mux_addr), .row_col_sel(row_col_sel),
        .mux_data_in(mux_data_in), .mux_we_b(mux_we_b), .mux_oe_b(mux_oe_b),
        .mux_data_out(mux_data_out), .mux_data_oe(mux_data_oe), .engine_busy(engine_busy),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_space_array(rd_space_array),
        .rd_data(rd_data), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_space_array(wr_space_array), .wr_from_mux(wr_from_mux), .wr_ready(wr_ready),
        .standby(standby), .mux_mode(mux_mode));
    lfp_host_model host_u (.clock(clock), .lad_out(lad_out), .lad_oe(lad_oe),
        .frame_b(frame_b), .lad_in(lad_in));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial forever #10 clock = ~clock;

    task automatic chk(input logic [40:0] g, input logic [40:0] x);
        comparisons = comparisons + 1;
        if (g !== x) begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task summarize;
        $display("mismatches=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task wait_q;
        for (n = 0; n < 200 && exp_q.size() != 0; n = n + 1) @(posedge clock);
        if (exp_q.size() != 0) begin
            err_count = err_count + 1;
            summarize;
        end
        repeat (2) @(posedge clock);
    endtask

    always @(posedge clock) begin
        if (rd_req === 1'b1) rd_last <= {rd_space_array, rd_addr};
        wr_gap <= wr_ready;
        // The queue outputs refresh the cycle after a pop, so one word is taken
        // every third cycle and the stale copy in between is skipped.
        if (drain_en && wr_valid === 1'b1 && !wr_ready && !wr_gap) begin
            chk({wr_from_mux, wr_addr, wr_data}, exp_q.size() ? exp_q.pop_front() : 0);
            wr_ready <= 1'b1;
        end else wr_ready <= 1'b0;
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        rows[0] = {4'h4, 32'hFFE01234, 8'h00, 5'h0D};
        rows[1] = {4'h5, 32'hFFA00055, 8'h00, 5'h0D};
        rows[2] = {4'h6, 32'hFFE00010, 8'hA5, 5'h0F};
        rows[3] = {4'h7, 32'hFFA00002, 8'h3C, 5'h0F};
        rows[4] = {4'h4, 32'hFFF00000, 8'h00, 5'h00};
        rows[5] = {4'h6, 32'hFF600000, 8'h11, 5'h00};
        rows[6] = {4'h2, 32'hFFE01234, 8'h22, 5'h00};
        rows[7] = {4'h8, 32'hFFE01234, 8'h00, 5'h00};
        repeat (3) @(posedge clock);
        chk({lad_oe, standby, wr_valid, mux_mode, rd_req}, 5'h08);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        for (i = 0; i < 8; i = i + 1) begin
            {t, a, d, e} = rows[i];
            // Address bit 31 is not carried by the write queue and reads back as zero.
            if (e != 0 && t[1]) exp_q.push_back({2'b00, a[30:0], d});
            host_u.cyc(t, a, d, 0, sc, rd);
            chk(sc, e);
            if (e != 0 && !t[1]) begin
                chk(rd, a[7:0] ^ 8'h5A);
                chk(rd_last, {a[22], a});
            end
        end
        host_u.cyc(4'h4, 32'hFFE00077, 8'h00, 2, sc, rd);
        chk({sc, rd}, {5'h0D, 8'h2D});
        host_u.nib(1'b0, 4'h0);
        host_u.nib(1'b1, 4'h4);
        repeat (4) host_u.nib(1'b1, 4'hE);
        host_u.nib(1'b0, 4'hF);
        host_u.nib(1'b1, 4'hF);
        for (n = 0; n < 16; n = n + 1) @(posedge clock) chk(lad_oe, 1'b0);
        chk(standby, 1'b1);
        engine_busy <= 1'b1;
        repeat (2) @(posedge clock);
        chk(standby, 1'b0);
        engine_busy <= 1'b0;
        host_u.cyc(4'h4, 32'hFFE01234, 8'h00, 0, sc, rd);
        chk(sc, 5'h0D);
        wait_q;
        drain_en <= 1'b0;
        for (i = 0; i < 9; i = i + 1) begin
            if (i < 8) exp_q.push_back({9'h07F, 16'hE001, i[7:0], i[7:0]});
            host_u.cyc(4'h6, {16'hFFE0, 8'h01, i[7:0]}, i[7:0], 0, sc, rd);
            chk(sc, i < 8 ? 5'h0F : 5'h00);
        end
        drain_en <= 1'b1;
        wait_q;
        mode_sel <= 1'b1;
        init_b <= 1'b0;
        repeat (2) @(posedge clock);
        chk({lad_oe, standby, wr_valid, mux_mode, rd_req}, 5'h08);
        init_b <= 1'b1;
        repeat (2) @(posedge clock);
        chk(mux_mode, 1'b1);
        host_u.cyc(4'h4, 32'hFFE01234, 8'h00, 0, sc, rd);
        chk(sc, 5'h00);
        exp_q.push_back({1'b1, 32'h00155155, 8'hC3});
        row_col_sel <= 1'b1;
        mux_addr <= 11'h155;
        mux_data_in <= 8'hC3;
        repeat (2) @(posedge clock);
        row_col_sel <= 1'b0;
        mux_addr <= 11'h2AA;
        repeat (2) @(posedge clock);
        mux_we_b <= 1'b0;
        repeat (2) @(posedge clock);
        mux_we_b <= 1'b1;
        mux_oe_b <= 1'b0;
        repeat (2) @(posedge clock);
        chk({mux_data_oe, mux_data_out}, 9'h10F);
        mux_oe_b <= 1'b1;
        wait_q;
        summarize;
    end
endmodule
